// file: scw_ctrl.sv
// scw_ctrl: low fields of the synth control word, keying multiplier and serial port
// assumes: pins arrive asynchronously and are synchronised here; sclk much slower than ref_clk
//
// Contract
// R1 - the mode field in bits 11 to 9 selects single tone, fsk, ramped fsk, chirp or bpsk.
// R2 - bit 8 set makes the update strobe pin an output driven by an internal update strobe.
// R3 - bit 8 clear makes the update strobe pin an input that the outside drives to update.
// R4 - the host writes zero to reserved bits 7, 3 and 2.
// R5 - bit 6 set sends synthesizer data straight to keying logic and stops the filter clock.
// R6 - bit 6 resets to zero so the filter is in the path and clocked.
// R7 - bit 5 set enables output amplitude ramping with the source chosen by bit 4.
// R8 - bit 4 set makes the keying factor internally and applies it to the cosine path.
// R9 - bit 4 clear, its reset value, takes the keying factor from the keying multiplier.
// R10 - the keying multiplier resets to zero so the scaled output is off after power-up; here osk_scale resets to full scale since keying is off.
// R11 - bit 1 picks serial bit order, zero msb first after reset, one lsb first.
// R12 - bit 0 enables the separate read-out pin and resets to zero, leaving it inactive.
// R13 - each transaction under chip select starts with an instruction byte, then data bytes.
// R14 - read data leaves on the data pin, or on the read-out pin when that pin is enabled.
`default_nettype none

module scw_ctrl
    import scw_pkg::*;
#(
    parameter int UPD_INTERVAL = 1024,
    parameter int RAMP_DIV = 4
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // serial programming port
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic sdio_in,
    output logic sdio_out,
    output logic sdio_oe,
    output logic serial_read_out,
    output logic serial_read_out_oe,
    // register update strobe pin
    input wire logic register_update_strobe_in,
    output logic register_update_strobe_out,
    output logic register_update_strobe_oe,
    // datapath
    input wire logic [OSK_W-1:0] dds_sample,
    input wire logic [OSK_W-1:0] isinc_sample,
    output logic [OSK_W-1:0] keying_sample,
    output logic [OSK_W-1:0] osk_scale,
    output logic isinc_clk_en,
    // decoded settings
    output scw_mode_t op_mode,
    output logic shaped_output_keying,
    output logic lsb_first
);

    ////////////////////////////////////////////////////////////////////////////////
    // pin synchronisers and edges

    scw_pins_t pin_raw;
    scw_pins_t pin_s;
    logic sclk_d;
    logic upd_d;
    logic sclk_rise;
    logic sclk_fall;
    logic upd_rise;

    assign pin_raw = '{sclk: sclk, cs_n: cs_n, sdio: sdio_in, upd: register_update_strobe_in};

    scw_sync #(.W($bits(scw_pins_t))) u_sync (
        .clk(ref_clk),
        .rst(rst),
        .d(pin_raw),
        .q(pin_s)
    );

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sclk_d <= 1'b0;
            upd_d <= 1'b0;
        end else begin
            sclk_d <= pin_s.sclk;
            upd_d <= pin_s.upd;
        end
    end

    assign sclk_rise = pin_s.sclk && !sclk_d;
    assign sclk_fall = !pin_s.sclk && sclk_d;
    assign upd_rise = pin_s.upd && !upd_d;

    ////////////////////////////////////////////////////////////////////////////////
    // registers: written into buffers, moved to active on an update strobe

    logic [CTRL_BITS-1:0] ctrl_buf;
    logic [CTRL_BITS-1:0] ctrl_act;
    logic [OSK_W-1:0] osk_buf;
    logic [OSK_W-1:0] osk_act;
    logic wr_commit;
    logic upd_evt;
    logic int_tick;
    logic [INSTR_ADDR_W-1:0] addr;
    logic [WORD_W-1:0] wr_word;

    scw_tick #(.PERIOD(UPD_INTERVAL)) u_upd_tick (
        .clk(ref_clk),
        .rst(rst),
        .en(ctrl_act[UPD_INT]),
        .tick(int_tick)
    );

    // a write in the same cycle as an update lands in the buffer and waits for the next one
    assign upd_evt = ctrl_act[UPD_INT] ? int_tick : upd_rise; // R2 R3

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ctrl_buf <= CTRL_RESET;
            osk_buf <= OSK_RESET; // R10
        end else if (wr_commit && addr == ADDR_CTRL) begin
            ctrl_buf <= wr_word[CTRL_BITS-1:0] & CTRL_WMASK; // R4
        end else if (wr_commit && addr == ADDR_OSK) begin
            osk_buf <= wr_word[OSK_W-1:0];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ctrl_act <= CTRL_RESET; // R6 R9 R11 R12
            osk_act <= OSK_RESET; // R10
        end else if (upd_evt) begin
            ctrl_act <= ctrl_buf;
            osk_act <= osk_buf;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // internal update strobe drive

    logic [1:0] upd_hold;

    always_ff @(posedge ref_clk) begin
        if (rst || !ctrl_act[UPD_INT]) begin
            upd_hold <= 2'h0;
            register_update_strobe_out <= 1'b0;
        end else if (int_tick) begin
            upd_hold <= 2'(UPD_PULSE_CYC - 1);
            register_update_strobe_out <= 1'b1; // R2
        end else if (upd_hold != 2'h0) begin
            upd_hold <= upd_hold - 2'h1;
        end else begin
            register_update_strobe_out <= 1'b0;
        end
    end

    assign register_update_strobe_oe = ctrl_act[UPD_INT]; // R2 R3

    ////////////////////////////////////////////////////////////////////////////////
    // serial port engine

    scw_sp_t state;
    logic [2:0] bit_cnt;
    logic [1:0] byte_cnt;
    logic [7:0] rx_sh;
    logic [7:0] rx_next;
    logic [1:0] reg_len;
    logic [1:0] byte_idx;
    logic [WORD_W-1:0] rd_word;
    logic [7:0] rd_byte;
    logic tx_bit;
    logic bit_last;

    assign lsb_first = ctrl_act[LSB_FIRST];
    assign bit_last = bit_cnt == 3'h7;
    assign rx_next = lsb_first ? {pin_s.sdio, rx_sh[7:1]} : {rx_sh[6:0], pin_s.sdio}; // R11

    always_comb begin
        if (addr == ADDR_CTRL) begin
            reg_len = LEN_CTRL;
            rd_word = WORD_W'(ctrl_act);
        end else if (addr == ADDR_OSK) begin
            reg_len = LEN_OSK;
            rd_word = WORD_W'(osk_act);
        end else begin
            reg_len = LEN_OTHER;
            rd_word = '0;
        end
    end

    // byte order follows bit order: lsb-first mode also sends the low byte first
    assign byte_idx = lsb_first ? byte_cnt : reg_len - byte_cnt; // R11
    assign rd_byte = rd_word[{byte_idx, 3'b000} +: 8];

    always_ff @(posedge ref_clk) begin
        if (rst || pin_s.cs_n) begin
            state <= SP_IDLE;
            bit_cnt <= 3'h0;
            byte_cnt <= 2'h0;
        end else begin
            unique case (state)
                SP_IDLE: begin
                    state <= SP_INSTR; // R13
                end
                SP_INSTR: begin
                    if (sclk_rise) begin
                        bit_cnt <= bit_cnt + 3'h1;
                        byte_cnt <= 2'h0;
                        if (bit_last) begin
                            state <= rx_next[INSTR_RD_BIT] ? SP_READ : SP_WRITE; // R13
                        end
                    end
                end
                SP_WRITE, SP_READ: begin
                    if (sclk_rise) begin
                        bit_cnt <= bit_cnt + 3'h1;
                        if (bit_last) begin
                            byte_cnt <= byte_cnt + 2'h1;
                            if (byte_cnt == reg_len) begin
                                state <= SP_INSTR; // R13
                            end
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rx_sh <= 8'h00;
            addr <= '0;
            wr_word <= '0;
            wr_commit <= 1'b0;
        end else begin
            wr_commit <= 1'b0;
            if (sclk_rise && (state == SP_INSTR || state == SP_WRITE)) begin
                rx_sh <= rx_next;
                if (bit_last && state == SP_INSTR) begin
                    addr <= rx_next[INSTR_ADDR_W-1:0];
                end
                if (bit_last && state == SP_WRITE) begin
                    wr_word[{byte_idx, 3'b000} +: 8] <= rx_next;
                    wr_commit <= byte_cnt == reg_len;
                end
            end
        end
    end

    // read bits change on falling sclk so the host samples them stable on the rise
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            tx_bit <= 1'b0;
        end else if (sclk_fall && state == SP_READ) begin
            tx_bit <= lsb_first ? rd_byte[bit_cnt] : rd_byte[3'h7 - bit_cnt]; // R11
        end
    end

    assign sdio_out = tx_bit;
    assign serial_read_out = tx_bit;
    assign sdio_oe = state == SP_READ && !ctrl_act[SDO_EN]; // R14
    assign serial_read_out_oe = ctrl_act[SDO_EN]; // R12 R14

    ////////////////////////////////////////////////////////////////////////////////
    // mode decode and output keying path

    logic ramp_tick;
    logic [OSK_W-1:0] ramp;
    logic ramp_on;

    assign shaped_output_keying = ctrl_act[OSK_EN];
    assign ramp_on = ctrl_act[OSK_EN] && ctrl_act[OSK_INT]; // R7 R8

    scw_tick #(.PERIOD(RAMP_DIV)) u_ramp_tick (
        .clk(ref_clk),
        .rst(rst),
        .en(ramp_on),
        .tick(ramp_tick)
    );

    always_ff @(posedge ref_clk) begin
        if (rst || !ramp_on) begin
            ramp <= OSK_RESET;
        end else if (ramp_tick && ramp != OSK_FULL) begin
            ramp <= ramp + 1'b1; // R8
        end
    end

    // undefined mode codes fall back to single tone
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            op_mode <= SCW_SINGLE;
        end else begin
            unique case (ctrl_act[MODE_HI:MODE_LO])
                MODE_SINGLE: op_mode <= SCW_SINGLE; // R1
                MODE_FSK: op_mode <= SCW_FSK; // R1
                MODE_RFSK: op_mode <= SCW_RFSK; // R1
                MODE_CHIRP: op_mode <= SCW_CHIRP; // R1
                MODE_BPSK: op_mode <= SCW_BPSK; // R1
                default: op_mode <= SCW_SINGLE;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            keying_sample <= '0;
            isinc_clk_en <= 1'b1; // R6
        end else begin
            keying_sample <= ctrl_act[ISINC_BYP] ? dds_sample : isinc_sample; // R5
            isinc_clk_en <= !ctrl_act[ISINC_BYP]; // R5
        end
    end

    // with keying off the multiplier passes full scale
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            osk_scale <= OSK_FULL;
        end else if (!ctrl_act[OSK_EN]) begin
            osk_scale <= OSK_FULL;
        end else if (ctrl_act[OSK_INT]) begin
            osk_scale <= ramp; // R7 R8
        end else begin
            osk_scale <= osk_act; // R9
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // checks

    mode_decode_a: assert property (@(posedge ref_clk) disable iff (rst) // R1
        ctrl_act[MODE_HI:MODE_LO] == MODE_BPSK |=> op_mode == SCW_BPSK)
        else $error("bpsk code not decoded");

    upd_out_dir_a: assert property (@(posedge ref_clk) disable iff (rst) // R2
        ctrl_act[UPD_INT] && int_tick
        |=> register_update_strobe_out && register_update_strobe_oe == $past(ctrl_buf[UPD_INT]))
        else $error("internal update strobe not driven");

    upd_in_dir_a: assert property (@(posedge ref_clk) disable iff (rst) // R3
        !ctrl_act[UPD_INT] && upd_rise
        |=> ctrl_act == $past(ctrl_buf) && register_update_strobe_oe == $past(ctrl_buf[UPD_INT]))
        else $error("external update did not load control word");

    rsv_bits_a: assert property (@(posedge ref_clk) disable iff (rst) // R4
        ctrl_buf[7] == 1'b0 && ctrl_buf[3:2] == 2'h0)
        else $error("reserved control bits not zero");

    isinc_bypass_a: assert property (@(posedge ref_clk) disable iff (rst) // R5
        ctrl_act[ISINC_BYP] |=> !isinc_clk_en && keying_sample == $past(dds_sample))
        else $error("filter bypass path wrong");

    reset_ctrl_a: assert property (@(posedge ref_clk) // R6
        $past(rst) && !rst |-> ctrl_act == CTRL_RESET && isinc_clk_en && !serial_read_out_oe)
        else $error("control word not cleared by reset");

    osk_int_a: assert property (@(posedge ref_clk) disable iff (rst) // R8
        ramp_on && $past(ramp_on) |=> osk_scale == $past(ramp))
        else $error("internal keying factor not applied");

    osk_ext_a: assert property (@(posedge ref_clk) disable iff (rst) // R9
        ctrl_act[OSK_EN] && !ctrl_act[OSK_INT] |=> osk_scale == $past(osk_act))
        else $error("keying factor not from multiplier");

    osk_reset_a: assert property (@(posedge ref_clk) // R10
        $past(rst) && !rst |-> osk_act == OSK_RESET && osk_buf == OSK_RESET)
        else $error("keying multiplier not cleared");

    bit_order_a: assert property (@(posedge ref_clk) disable iff (rst) // R11
        state == SP_INSTR && sclk_rise && lsb_first |=> rx_sh[7] == $past(pin_s.sdio))
        else $error("lsb first shift wrong");

    read_pin_a: assert property (@(posedge ref_clk) disable iff (rst) // R14
        state == SP_READ |-> sdio_oe != serial_read_out_oe)
        else $error("read data on wrong pin");

    instr_len_a: assert property (@(posedge ref_clk) disable iff (rst) // R13
        $past(state) == SP_INSTR && state != SP_INSTR && !$past(pin_s.cs_n)
        |-> $past(bit_cnt) == 3'h7 && $past(sclk_rise))
        else $error("instruction not eight bits");

endmodule : scw_ctrl

`default_nettype wire

// file: scw_host.sv
// scw_host: host model that programs the control block over the serial port
// assumes: driven on the falling edge of ref_clk; sclk 4 cycles high, 4 low
`default_nettype none

module scw_host
    import scw_pkg::*;
(
    // clock
    input wire logic ref_clk,
    // serial pins
    output logic sclk,
    output logic cs_n,
    output logic sdio_in,
    input wire logic sdio_out,
    input wire logic sdio_oe,
    input wire logic serial_read_out
);
    timeunit 1ns;
    timeprecision 1ps;

    logic host_oe;
    logic host_d;
    logic idle_pat;

    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        host_oe = 1'b0;
        host_d = 1'b0;
        idle_pat = 1'b0;
    end

    // a released line toggles, so a stale bit never reads as valid data
    always @(negedge ref_clk) begin
        idle_pat <= ~idle_pat;
    end

    // device drive wins on the shared data line
    assign sdio_in = sdio_oe ? sdio_out : (host_oe ? host_d : idle_pat);

    ////////////////////////////////////////////////////////////////////////////////
    // one transaction: instruction byte then nbytes of data, clock idles low
    task automatic xfer(input logic [7:0] instr, input logic [31:0] wdata, input int nbytes,
                        input bit lsb, input bit use_sro, output logic [31:0] rdata);
        int nb;
        int k;
        rdata = 32'h0000_0000;
        nb = 8 + 8 * nbytes;
        @(negedge ref_clk);
        cs_n = 1'b0;
        host_oe = 1'b1;
        repeat (5) @(negedge ref_clk);
        for (int i = 0; i < nb; i++) begin
            // bit order reverses the whole frame, bytes included
            k = (i < 8) ? (lsb ? i : 7 - i) : (lsb ? i - 8 : nb - 1 - i);
            if (i < 8) begin
                host_d = instr[k];
            end else if (!instr[INSTR_RD_BIT]) begin
                host_d = wdata[k];
            end
            repeat (4) @(negedge ref_clk);
            if (i >= 8) begin
                rdata[k] = use_sro ? serial_read_out : sdio_in;
            end
            sclk = 1'b1;
            repeat (4) @(negedge ref_clk);
            sclk = 1'b0;
            if (i == 7 && instr[INSTR_RD_BIT]) begin
                host_oe = 1'b0;
            end
        end
        repeat (4) @(negedge ref_clk);
        cs_n = 1'b1;
        host_oe = 1'b0;
        repeat (6) @(negedge ref_clk);
    endtask : xfer
endmodule : scw_host

`default_nettype wire

// file: scw_pkg.sv
// scw_pkg: constants, field positions and types for the synth control word block
// assumes: one 50 MHz system clock, serial programming port sampled on that clock
`default_nettype none

package scw_pkg;

    // clock and timing
    localparam int CLK_PERIOD_NS = 20;
    localparam int UPD_PULSE_NS = 60;
    localparam int UPD_PULSE_CYC = (UPD_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // widths
    localparam int CTRL_BITS = 12;
    localparam int OSK_W = 12;
    localparam int WORD_W = 32;

    // instruction byte layout
    localparam int INSTR_RD_BIT = 7;
    localparam int INSTR_ADDR_W = 4;

    // register addresses and lengths (length in bytes minus one)
    localparam logic [3:0] ADDR_CTRL = 4'h7;
    localparam logic [3:0] ADDR_OSK = 4'h8;
    localparam logic [1:0] LEN_CTRL = 2'h3;
    localparam logic [1:0] LEN_OSK = 2'h1;
    localparam logic [1:0] LEN_OTHER = 2'h0;

    // control word field positions
    localparam int MODE_HI = 11;
    localparam int MODE_LO = 9;
    localparam int UPD_INT = 8;
    localparam int ISINC_BYP = 6;
    localparam int OSK_EN = 5;
    localparam int OSK_INT = 4;
    localparam int LSB_FIRST = 1;
    localparam int SDO_EN = 0;

    // writable bits: reserved 7, 3 and 2 held at zero
    localparam logic [CTRL_BITS-1:0] CTRL_WMASK = 12'hF73;
    localparam logic [CTRL_BITS-1:0] CTRL_RESET = 12'h000;
    localparam logic [OSK_W-1:0] OSK_RESET = 12'h000;
    localparam logic [OSK_W-1:0] OSK_FULL = 12'hFFF;

    // mode field codes
    localparam logic [2:0] MODE_SINGLE = 3'h0;
    localparam logic [2:0] MODE_FSK = 3'h1;
    localparam logic [2:0] MODE_RFSK = 3'h2;
    localparam logic [2:0] MODE_CHIRP = 3'h3;
    localparam logic [2:0] MODE_BPSK = 3'h4;

    typedef enum logic [4:0] {
        SCW_SINGLE = 5'b00001,
        SCW_FSK = 5'b00010,
        SCW_RFSK = 5'b00100,
        SCW_CHIRP = 5'b01000,
        SCW_BPSK = 5'b10000
    } scw_mode_t;

    typedef enum logic [3:0] {
        SP_IDLE = 4'b0001,
        SP_INSTR = 4'b0010,
        SP_WRITE = 4'b0100,
        SP_READ = 4'b1000
    } scw_sp_t;

    typedef struct packed {
        logic sclk;
        logic cs_n;
        logic sdio;
        logic upd;
    } scw_pins_t;

endpackage : scw_pkg

`default_nettype wire

// file: scw_sync.sv
// scw_sync: two-flop synchroniser for a group of pin levels
// assumes: inputs asynchronous to clk; only q is read downstream
`default_nettype none

module scw_sync #(
    parameter int W = 4
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // levels
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [W-1:0] meta;

    always_ff @(posedge clk) begin
        if (rst) begin
            meta <= '0;
            q <= '0;
        end else begin
            meta <= d;
            q <= meta;
        end
    end

endmodule : scw_sync

`default_nettype wire

// file: scw_tick.sv
// scw_tick: divider giving a one-cycle enable every PERIOD cycles
// assumes: PERIOD of at least 2; count restarts whenever en drops
`default_nettype none

module scw_tick #(
    parameter int PERIOD = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // control
    input wire logic en,
    output logic tick
);

    localparam int CW = $clog2(PERIOD);

    logic [CW-1:0] cnt;

    always_ff @(posedge clk) begin
        if (rst || !en) begin
            cnt <= '0;
            tick <= 1'b0;
        end else if (cnt == CW'(PERIOD - 1)) begin
            cnt <= '0;
            tick <= 1'b1;
        end else begin
            cnt <= cnt + 1'b1;
            tick <= 1'b0;
        end
    end

endmodule : scw_tick

`default_nettype wire

// file: tb_top.sv
// tb_top: self-checking bench for the synth control word block
// assumes: scw_pkg compiled first; host model drives the serial pins
`default_nettype none

module tb_top
    import scw_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic ref_clk;
    logic rst;
    logic sclk;
    logic cs_n;
    logic sdio_in;
    logic sdio_out;
    logic sdio_oe;
    logic serial_read_out;
    logic serial_read_out_oe;
    logic ext_upd;
    logic upd_wire;
    logic register_update_strobe_out;
    logic register_update_strobe_oe;
    logic [OSK_W-1:0] dds_sample;
    logic [OSK_W-1:0] isinc_sample;
    logic [OSK_W-1:0] keying_sample;
    logic [OSK_W-1:0] osk_scale;
    logic isinc_clk_en;
    scw_mode_t op_mode;
    logic shaped_output_keying;
    logic lsb_first;
    int bad_count;
    int n_checks;
    bit cur_lsb;
    bit cur_sro;
    bit oe_seen;
    logic [31:0] rv;

    assign upd_wire = register_update_strobe_oe ? register_update_strobe_out : ext_upd;

    scw_ctrl #(.UPD_INTERVAL(16), .RAMP_DIV(2)) i_scw_ctrl (
        .ref_clk(ref_clk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .sdio_in(sdio_in),
        .sdio_out(sdio_out), .sdio_oe(sdio_oe), .serial_read_out(serial_read_out),
        .serial_read_out_oe(serial_read_out_oe), .register_update_strobe_in(upd_wire),
        .register_update_strobe_out(register_update_strobe_out),
        .register_update_strobe_oe(register_update_strobe_oe), .dds_sample(dds_sample),
        .isinc_sample(isinc_sample), .keying_sample(keying_sample), .osk_scale(osk_scale),
        .isinc_clk_en(isinc_clk_en), .op_mode(op_mode),
        .shaped_output_keying(shaped_output_keying), .lsb_first(lsb_first)
    );

    scw_host i_scw_host (
        .ref_clk(ref_clk), .sclk(sclk), .cs_n(cs_n), .sdio_in(sdio_in),
        .sdio_out(sdio_out), .sdio_oe(sdio_oe), .serial_read_out(serial_read_out)
    );

    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk) begin
        if (sdio_oe === 1'b1) oe_seen <= 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic close_out;
        $display("checks %0d errors %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : close_out

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [3:0] addr, input logic [31:0] d, input int nbytes);
        logic [31:0] dummy;
        i_scw_host.xfer({4'h0, addr}, d, nbytes, cur_lsb, 1'b0, dummy);
    endtask : wr

    task automatic rd(input logic [3:0] addr, input int nbytes, output logic [31:0] d);
        i_scw_host.xfer({4'h8, addr}, 32'h0000_0000, nbytes, cur_lsb, cur_sro, d);
    endtask : rd

    task automatic strobe;
        ext_upd = 1'b1;
        repeat (4) @(negedge ref_clk);
        ext_upd = 1'b0;
        repeat (8) @(negedge ref_clk);
    endtask : strobe

    // reserved bits never leave the host set
    task automatic set_ctrl(input logic [CTRL_BITS-1:0] v);
        wr(ADDR_CTRL, {20'h00000, v & CTRL_WMASK}, 4);
        strobe();
        cur_lsb = v[LSB_FIRST];
        cur_sro = v[SDO_EN];
    endtask : set_ctrl

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        chk("op_mode", SCW_SINGLE, op_mode);
        chk("isinc_clk_en", 1, isinc_clk_en);
        chk("keying_off", 0, shaped_output_keying);
        chk("lsb_first", 0, lsb_first);
        chk("sro_oe", 0, serial_read_out_oe);
        chk("upd_oe", 0, register_update_strobe_oe);
        rd(ADDR_CTRL, 4, rv);
        chk("ctrl_reset", 0, rv);
        rd(ADDR_OSK, 2, rv);
        chk("osk_reset", 0, rv);
    endtask : t_reset

    task automatic t_modes;
        logic [2:0] codes [5] = '{MODE_FSK, MODE_RFSK, MODE_CHIRP, MODE_BPSK, MODE_SINGLE};
        logic [4:0] prev;
        prev = 5'h01;
        foreach (codes[m]) begin
            wr(ADDR_CTRL, {20'h00000, codes[m], 9'h000}, 4);
            chk("mode_held", prev, op_mode);
            strobe();
            prev = 5'h01 << codes[m];
            chk("op_mode", prev, op_mode);
        end
    endtask : t_modes

    task automatic t_isinc;
        chk("filtered", 12'h456, keying_sample);
        set_ctrl(12'h040);
        chk("isinc_clk_en", 0, isinc_clk_en);
        chk("bypassed", 12'h123, keying_sample);
    endtask : t_isinc

    task automatic t_osk;
        wr(ADDR_OSK, 32'h0000_0ABC, 2);
        set_ctrl(12'h020);
        chk("keying_on", 1, shaped_output_keying);
        chk("user_scale", 12'hABC, osk_scale);
        set_ctrl(12'h030);
        chk("ramp_low", 1, osk_scale < 12'h040);
        // full ramp takes 0xFFF steps of two cycles
        repeat (8300) @(negedge ref_clk);
        chk("ramp_top", 12'hFFF, osk_scale);
    endtask : t_osk

    task automatic t_order;
        set_ctrl(12'h002);
        chk("lsb_first", 1, lsb_first);
        wr(ADDR_OSK, 32'h0000_0123, 2);
        strobe();
        rd(ADDR_OSK, 2, rv);
        chk("osk_lsb", 12'h123, rv);
        rd(ADDR_CTRL, 4, rv);
        chk("ctrl_lsb", 12'h002, rv);
    endtask : t_order

    task automatic t_sro;
        set_ctrl(12'h003);
        chk("sro_oe", 1, serial_read_out_oe);
        oe_seen = 1'b0;
        rd(ADDR_CTRL, 4, rv);
        chk("ctrl_sro", 12'h003, rv);
        chk("sdio_quiet", 0, oe_seen);
        set_ctrl(12'h000);
        rd(ADDR_CTRL, 4, rv);
        chk("ctrl_sdio", 0, rv);
    endtask : t_sro

    task automatic t_internal;
        int n;
        n = 0;
        set_ctrl(12'h700);
        chk("upd_oe", 1, register_update_strobe_oe);
        while (register_update_strobe_out !== 1'b1 && n < 40) begin
            @(negedge ref_clk);
            n++;
        end
        n = 0;
        while (register_update_strobe_out === 1'b1 && n < 10) begin
            @(negedge ref_clk);
            n++;
        end
        chk("pulse_len", UPD_PULSE_CYC, n);
        wr(ADDR_CTRL, 32'h0000_0900, 4);
        repeat (40) @(negedge ref_clk);
        chk("self_update", SCW_BPSK, op_mode);
    endtask : t_internal

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        rst = 1'b1;
        ext_upd = 1'b0;
        dds_sample = 12'h123;
        isinc_sample = 12'h456;
        bad_count = 0;
        n_checks = 0;
        cur_lsb = 1'b0;
        cur_sro = 1'b0;
        oe_seen = 1'b0;
        repeat (2) @(negedge ref_clk);
        rst = 1'b0;
        repeat (10) @(negedge ref_clk);
        t_reset();
        t_modes();
        t_isinc();
        t_osk();
        t_order();
        t_sro();
        t_internal();
        close_out();
    end

    // whole run is near 15000 cycles
    initial begin
        repeat (60000) @(posedge ref_clk);
        bad_count++;
        $display("ERROR watchdog expected done seen hang");
        close_out();
    end
endmodule : tb_top

`default_nettype wire
